// ===== core/spk_host_port.sv
// Top of the speakerphone host serial port and its duplex control.
// Assumes strobe, frame and data come from a host on its own clock, and the
// echo return loss figures and utterance pulses come from core-clock logic.
`timescale 1ns/10ps
`default_nettype none
module spk_host_port
  import spk_pkg::*;
(
  input wire logic clk,             // Core clock.
  input wire logic rstn,            // Chip reset, active low.
  input wire logic strobe_clk,      // Serial strobe from the host.
  input wire logic frame_valid_n,   // Frame from the host, active low.
  input wire logic serial_data,     // Serial data from the host.
  input wire logic [7:0] acoustic_erle, // Measured acoustic return loss.
  input wire logic [7:0] network_erle,  // Measured network return loss.
  input wire logic utterance_done,  // One-cycle pulse per passed utterance.
  output spk_ctrl_t ctrl_q,         // Control to the echo-cancelling core.
  output logic cfg_updated_q,       // Pulse after a register write.
  output logic [NUM_REGS-1:0][DATA_W-1:0] cfg_image_q // Register contents.
);

  // Strobe-domain receiver and crossing.

  spk_word_t link_word;
  logic link_tgl;
  logic tgl_sync;
  logic tgl_seen_q;

  spk_link_rx u_rx (
    .strobe_clk(strobe_clk),
    .rstn(rstn),
    .frame_valid_n(frame_valid_n),
    .serial_data(serial_data),
    .word_q(link_word),
    .word_tgl_q(link_tgl)
  );

  // Only the toggle crosses; the word is held steady in the strobe domain.
  spk_sync u_sync (
    .clk(clk),
    .rstn(rstn),
    .din(link_tgl),
    .dout(tgl_sync)
  );

  // A change of the synchronised toggle marks one whole committed word.
  // The word is safe to read: another word needs fourteen more strobe edges,
  // each no faster than the core clock, long after the crossing settles.
  wire commit_w = tgl_sync ^ tgl_seen_q;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tgl_seen_q <= 1'b0;
    end else begin
      tgl_seen_q <= tgl_sync;
    end
  end

  // Configuration registers, one per index.

  // Each register is its own flop group; the packed view is a net so that every
  // loop entry drives only its own slice and no variable has two writers.
  wire [NUM_REGS-1:0][DATA_W-1:0] regs_q;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_REGS; gi++) begin : g_reg
      logic [DATA_W-1:0] slot_q;
      wire hit_w = commit_w && (link_word.addr == ADDR_W'(gi));

      always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          slot_q <= CFG_RESET[gi];
        end else if (hit_w) begin
          slot_q <= link_word.data;
        end
      end

      assign regs_q[gi] = slot_q;
    end
  endgenerate

  // Field decode.

  wire tx_supp_dis_w = regs_q[REG_MODE_A][F_TX_SUPP_DIS];
  wire ac_clr_w = regs_q[REG_MODE_A][F_AC_COEF_CLR];
  wire hd_dis_w = regs_q[REG_MODE_N][F_HD_DIS];
  wire rx_supp_dis_w = regs_q[REG_MODE_N][F_RX_SUPP_DIS];
  wire [1:0] taps_w = regs_q[REG_MODE_N][F_TAPS_LO+1:F_TAPS_LO];
  wire nc_clr_w = regs_q[REG_MODE_N][F_NC_COEF_CLR];
  wire [7:0] net_thr_w = regs_q[REG_NET_THR];
  wire [7:0] ac_thr_w = regs_q[REG_AC_THR];

  // Duplex qualification terms.

  wire both_clr_w = ac_clr_w && nc_clr_w;
  wire all_ac_w = (taps_w == TAPS_ALL_ACOUSTIC);
  wire ac_ok_w = (acoustic_erle >= ac_thr_w);
  wire nc_ok_w = all_ac_w || (network_erle >= net_thr_w);

  // Utterances passed since reset or since both cancellers were cleared.

  logic [2:0] utter_q;
  wire trained_w = (utter_q == UTTER_MIN);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      utter_q <= 3'h0;
    end else if (both_clr_w) begin
      utter_q <= 3'h0;
    end else if (utterance_done && !trained_w) begin
      utter_q <= utter_q + 3'h1;
    end
  end

  // Entry needs training and return loss, unless half duplex is bypassed.
  // Clearing both cancellers overrides every other setting.
  wire go_full_w = !both_clr_w && (hd_dis_w || (trained_w && ac_ok_w && nc_ok_w));
  wire stay_full_w = !both_clr_w && (hd_dis_w || ac_ok_w);

  spk_dpx_t dpx_q;
  spk_dpx_t dpx_d;

  always_comb begin
    case (dpx_q)
      DPX_HALF: begin
        dpx_d = go_full_w ? DPX_FULL : DPX_HALF;
      end
      DPX_FULL: begin
        dpx_d = stay_full_w ? DPX_FULL : DPX_HALF;
      end
      default: begin
        dpx_d = DPX_HALF;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      dpx_q <= DPX_HALF;
    end else begin
      dpx_q <= dpx_d;
    end
  end

  // Control outputs, registered so the core sees clean levels.

  spk_ctrl_t ctrl_d;

  always_comb begin
    ctrl_d = CTRL_IDLE;
    ctrl_d.core_active = 1'b1;
    ctrl_d.half_duplex = (dpx_d == DPX_HALF);
    ctrl_d.tx_supp_en = !tx_supp_dis_w;
    ctrl_d.rx_supp_en = !rx_supp_dis_w;
    ctrl_d.ac_adapt = !ac_clr_w;
    ctrl_d.ac_clear = ac_clr_w;
    ctrl_d.nc_adapt = !nc_clr_w;
    ctrl_d.nc_clear = nc_clr_w;
  end

  // Reset holds every control low, which idles the whole core.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_q <= CTRL_IDLE;
      cfg_updated_q <= 1'b0;
      cfg_image_q <= CFG_RESET;
    end else begin
      ctrl_q <= ctrl_d;
      cfg_updated_q <= commit_w;
      cfg_image_q <= regs_q;
    end
  end

  // Checks on the core-clock behaviour.
  // They wait one clock past reset release: at the releasing edge the flops
  // still load their reset values, so a check begun there would see idle outputs.

  logic chk_en_q;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      chk_en_q <= 1'b0;
    end else begin
      chk_en_q <= 1'b1;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!chk_en_q);

  sequence s_word_arrives;
    commit_w;
  endsequence

  sequence s_ready_to_switch;
    dpx_q == DPX_HALF && !both_clr_w && trained_w && ac_ok_w;
  endsequence

  sequence s_utter_counted;
    utterance_done && !trained_w && !both_clr_w;
  endsequence

  a_write_on_commit: assert property (
    s_word_arrives |=> regs_q[$past(link_word.addr)] == $past(link_word.data) && cfg_updated_q
      ##1 cfg_image_q == $past(regs_q))
    else $error("Committed word not written to its register.");

  a_hold_without_word: assert property (
    !commit_w |=> $stable(regs_q))
    else $error("Register changed without a committed word.");

  a_both_clear_half: assert property (
    both_clr_w [*2] |=> ctrl_q.half_duplex)
    else $error("Full duplex entered with both cancellers cleared.");

  a_untrained_half: assert property (
    (dpx_q == DPX_HALF && !trained_w && !hd_dis_w) |=> ctrl_q.half_duplex)
    else $error("Left half duplex before enough utterances.");

  a_erle_to_full: assert property (
    (s_ready_to_switch and (nc_ok_w && !all_ac_w)) |=> !ctrl_q.half_duplex)
    else $error("Acoustic threshold reached but still half duplex.");

  a_low_erle_half: assert property (
    (dpx_q == DPX_HALF && !ac_ok_w && !hd_dis_w) |=> ctrl_q.half_duplex)
    else $error("Full duplex entered below the acoustic threshold.");

  a_all_taps_full: assert property (
    (s_ready_to_switch and all_ac_w) |=> !ctrl_q.half_duplex)
    else $error("All-acoustic taps did not allow full duplex.");

  a_hd_bypass: assert property (
    (!both_clr_w && hd_dis_w) |=> !ctrl_q.half_duplex)
    else $error("Half duplex bypass ignored.");

  a_supp_bypass: assert property (
    ##1 ctrl_q.tx_supp_en == !$past(tx_supp_dis_w)
      && ctrl_q.rx_supp_en == !$past(rx_supp_dis_w))
    else $error("Suppression enable does not follow its bypass.");

  a_acoustic_coef: assert property (
    ac_clr_w |=> ctrl_q.ac_clear && !ctrl_q.ac_adapt)
    else $error("Acoustic coefficients not held cleared.");

  a_acoustic_adapt: assert property (
    !ac_clr_w |=> ctrl_q.ac_adapt && !ctrl_q.ac_clear)
    else $error("Acoustic filter not adapting when set to normal.");

  a_active_after_reset: assert property (
    1'b1 |=> ctrl_q.core_active)
    else $error("Core not active after reset release.");

  // Update pulse, register image, training counter, full-duplex hold, state encoding and network coefficients.

  a_update_single: assert property (
    cfg_updated_q |=> !cfg_updated_q)
    else $error("Update pulse lasted more than one cycle.");

  a_image_follows: assert property (
    ##1 cfg_image_q == $past(regs_q))
    else $error("Register image does not follow the registers.");

  a_utter_count: assert property (
    s_utter_counted |=> utter_q == $past(utter_q) + 3'h1)
    else $error("Passed utterance not counted.");

  a_trained_holds: assert property (
    (trained_w && !both_clr_w) |=> trained_w)
    else $error("Training lost without a coefficient clear.");

  a_clear_restarts: assert property (
    both_clr_w |=> utter_q == 3'h0)
    else $error("Utterance count kept while both cancellers cleared.");

  a_full_holds: assert property (
    (dpx_q == DPX_FULL && !both_clr_w && ac_ok_w) |=> !ctrl_q.half_duplex)
    else $error("Left full duplex while above the acoustic threshold.");

  a_state_legal: assert property (
    dpx_q == DPX_HALF || dpx_q == DPX_FULL)
    else $error("Duplex state left its legal codes.");

  a_network_coef: assert property (
    nc_clr_w |=> ctrl_q.nc_clear && !ctrl_q.nc_adapt)
    else $error("Network coefficients not held cleared.");

endmodule
`default_nettype wire

// ===== include/spk_pkg.sv
// Shared constants and types for the speakerphone host serial port.
// Assumes each design file that uses it imports the whole package in its module header.
package spk_pkg;

  // Serial word layout: two address bits then eight data bits, MSB first.
  localparam int ADDR_W = 2;
  localparam int DATA_W = 8;
  localparam int NUM_REGS = 4;
  localparam logic [3:0] WORD_BITS = 4'hA;
  localparam logic [3:0] BIT_CNT_MAX = 4'hF;

  // Index of the fourth strobe edge after the frame ends.
  localparam logic [2:0] TRAIL_LAST = 3'h3;

  // Configuration register indices.
  localparam logic [1:0] REG_MODE_A = 2'h0;
  localparam logic [1:0] REG_MODE_N = 2'h1;
  localparam logic [1:0] REG_NET_THR = 2'h2;
  localparam logic [1:0] REG_AC_THR = 2'h3;

  // Field positions inside registers 0 and 1.
  localparam int F_TX_SUPP_DIS = 0;
  localparam int F_AC_COEF_CLR = 1;
  localparam int F_HD_DIS = 0;
  localparam int F_RX_SUPP_DIS = 1;
  localparam int F_TAPS_LO = 2;
  localparam int F_NC_COEF_CLR = 4;

  // Tap allocation code that gives every tap to the acoustic canceller.
  localparam logic [1:0] TAPS_ALL_ACOUSTIC = 2'h3;

  // Values after reset, register 3 in the top byte.
  localparam logic [NUM_REGS-1:0][DATA_W-1:0] CFG_RESET = {8'h18, 8'h20, 8'h00, 8'h00};

  // Passed utterances needed before full duplex may be entered.
  localparam logic [2:0] UTTER_MIN = 3'h3;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } spk_word_t;

  typedef struct packed {
    logic core_active;
    logic half_duplex;
    logic tx_supp_en;
    logic rx_supp_en;
    logic ac_adapt;
    logic ac_clear;
    logic nc_adapt;
    logic nc_clear;
  } spk_ctrl_t;

  localparam spk_ctrl_t CTRL_IDLE = 8'h00;

  typedef enum logic [1:0] {
    DPX_HALF = 2'b01,
    DPX_FULL = 2'b10
  } spk_dpx_t;

endpackage

// ===== core/spk_sync.sv
// Two-stage level synchroniser into the core clock.
// Assumes the input is a level that stays put for several core cycles.
`timescale 1ns/10ps
`default_nettype none
module spk_sync (
  input wire logic clk,    // Core clock.
  input wire logic rstn,   // Asynchronous reset, active low.
  input wire logic din,    // Level from the strobe domain.
  output logic dout        // Synchronised level.
);

  logic meta_q;
  logic sync_q;

  // The first stage feeds only the second, so metastability never reaches logic.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      meta_q <= din;
      sync_q <= meta_q;
    end
  end

  assign dout = sync_q;

endmodule
`default_nettype wire

// ===== core/spk_link_rx.sv
// Strobe-domain receiver of the serial configuration word.
// Assumes the strobe may stop outside frames and the host gives trailing edges.
`timescale 1ns/10ps
`default_nettype none
module spk_link_rx
  import spk_pkg::*;
(
  input wire logic strobe_clk,     // Strobe from the host.
  input wire logic rstn,           // Asynchronous reset, active low.
  input wire logic frame_valid_n,  // Frame, active low.
  input wire logic serial_data,    // Serial data.
  output spk_word_t word_q,        // Last committed word.
  output logic word_tgl_q          // Toggles once per committed word.
);

  logic [9:0] shift_q;
  logic [3:0] cnt_q;
  logic [2:0] trail_q;
  logic armed_q;
  wire commit_w = frame_valid_n && armed_q && (trail_q == TRAIL_LAST);

  // Bits shift in only inside the frame; a wrong bit count is dropped at commit.
  always_ff @(posedge strobe_clk or negedge rstn) begin
    if (!rstn) begin
      shift_q <= 10'h000;
      cnt_q <= 4'h0;
      trail_q <= 3'h0;
      armed_q <= 1'b0;
      word_q <= '0;
      word_tgl_q <= 1'b0;
    end else if (!frame_valid_n) begin
      shift_q <= {shift_q[8:0], serial_data};
      cnt_q <= (cnt_q == BIT_CNT_MAX) ? cnt_q : cnt_q + 4'h1;
      trail_q <= 3'h0;
      armed_q <= 1'b1;
    end else if (armed_q) begin
      trail_q <= trail_q + 3'h1;
      if (commit_w) begin
        armed_q <= 1'b0;
        cnt_q <= 4'h0;
        if (cnt_q == WORD_BITS) begin
          word_q <= shift_q;
          word_tgl_q <= ~word_tgl_q;
        end
      end
    end
  end

  default clocking @(posedge strobe_clk); endclocking
  default disable iff (!rstn);

  a_sample_in_frame: assert property (
    !frame_valid_n |=> shift_q[0] == $past(serial_data))
    else $error("Data bit not sampled inside the frame.");

  a_idle_no_shift: assert property (
    (frame_valid_n && !armed_q) |=> $stable(shift_q))
    else $error("Shift register moved outside a frame.");

  sequence s_frame_end_good;
    $rose(frame_valid_n) && cnt_q == WORD_BITS;
  endsequence

  a_commit_fourth: assert property (
    s_frame_end_good ##0 frame_valid_n [*4] |=> $changed(word_tgl_q))
    else $error("Word not committed on the fourth trailing strobe.");

  a_no_early_commit: assert property (
    $rose(frame_valid_n) |-> $stable(word_tgl_q) [*3])
    else $error("Word committed before the fourth trailing strobe.");

endmodule
`default_nettype wire

// ===== verification/spk_host_model.sv
// Host model that writes words through the serial configuration port.
// Assumes the bench calls send only after reset is released.
`timescale 1ns/10ps
`default_nettype none
module spk_host_model (
  output logic strobe_clk,    // Strobe, still outside frames except for the trailing edges.
  output logic frame_valid_n, // Frame, active low.
  output logic serial_data    // Serial data.
);
  // Idle host: frame high, strobe stopped low.
  initial begin
    strobe_clk = 1'b0;
    frame_valid_n = 1'b1;
    serial_data = 1'b0;
  end

  // One 15 ns strobe cycle, so it never outruns the 10 ns core clock.
  task automatic pulse();
    #3.75 strobe_clk = 1'b1;
    #7.5 strobe_clk = 1'b0;
    #3.75;
  endtask

  // Sends the low n bits of w, MSB first, then the trailing strobes.
  task automatic send(input logic [15:0] w, input int n);
    frame_valid_n = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      serial_data = w[i];
      pulse();
    end
    frame_valid_n = 1'b1;
    serial_data = ~serial_data; // A released line must not keep its last value.
    repeat (4) pulse();
  endtask
endmodule
`default_nettype wire

// ===== verification/speakerphone_host_serial_port_test.sv
// Self-checking bench of the host serial port and its duplex control.
// Assumes the host model drives the strobe domain and the bench the core inputs.
`timescale 1ns/10ps
`default_nettype none
module speakerphone_host_serial_port_test
  import spk_pkg::*;
;
  logic clk, rstn, strobe_clk, frame_valid_n, serial_data, utterance_done, cfg_updated_q;
  logic [7:0] acoustic_erle, network_erle;
  spk_ctrl_t ctrl_q;
  logic [NUM_REGS-1:0][DATA_W-1:0] cfg_image_q;
  int bad_count = 0;
  int n_compared = 0;
  int cyc = 0;

  spk_host_model host (.strobe_clk(strobe_clk), .frame_valid_n(frame_valid_n),
    .serial_data(serial_data));
  spk_host_port dut (.clk(clk), .rstn(rstn), .strobe_clk(strobe_clk),
    .frame_valid_n(frame_valid_n), .serial_data(serial_data), .acoustic_erle(acoustic_erle),
    .network_erle(network_erle), .utterance_done(utterance_done), .ctrl_q(ctrl_q),
    .cfg_updated_q(cfg_updated_q), .cfg_image_q(cfg_image_q));

  // Core clock of 10 ns.
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic summarize();
    if (bad_count == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  // Cuts a hang short; the whole run needs far fewer cycles.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      summarize();
    end
  end

  // Writes one register and waits, bounded, for the update pulse.
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    int k = 0;
    host.send({6'h00, a, d}, 10);
    while (cfg_updated_q !== 1'b1 && k < 12) begin
      @(posedge clk);
      #1;
      k++;
    end
    chk({31'h0, cfg_updated_q}, 32'h1);
    @(posedge clk);
    #1;
  endtask

  task automatic utter(input int n);
    repeat (n) begin
      @(posedge clk) utterance_done <= 1'b1;
      @(posedge clk) utterance_done <= 1'b0;
    end
    repeat (2) @(posedge clk);
    #1;
  endtask

  // A nine-bit frame must be dropped without touching any register.
  task automatic short_frame();
    logic [31:0] seen = 32'h0;
    fork
      host.send(16'h03FF, 9);
      repeat (40) @(posedge clk) seen = seen + {31'h0, cfg_updated_q};
    join
    chk(seen, 32'h0);
    chk(cfg_image_q[3], 8'h40);
  endtask

  // Training, threshold and tap allocation decide the duplex state.
  task automatic duplex();
    wr(REG_MODE_N, 8'h0C);
    @(posedge clk) acoustic_erle <= 8'h50;
    utter(2);
    chk(ctrl_q.half_duplex, 32'h1);
    utter(1);
    chk(ctrl_q.half_duplex, 32'h0);
    @(posedge clk) acoustic_erle <= 8'h3F;
    repeat (3) @(posedge clk);
    #1;
    chk(ctrl_q.half_duplex, 32'h1);
    // Split taps: the network canceller must reach its own threshold too.
    wr(REG_MODE_N, 8'h00);
    @(posedge clk) acoustic_erle <= 8'h50;
    repeat (3) @(posedge clk);
    #1;
    chk(ctrl_q.half_duplex, 32'h1);
    @(posedge clk) network_erle <= 8'h20;
    repeat (3) @(posedge clk);
    #1;
    chk(ctrl_q.half_duplex, 32'h0);
  endtask

  // Bypass bits and coefficient controls at the control outputs.
  task automatic bypass_and_clear();
    wr(REG_MODE_A, 8'h01);
    wr(REG_MODE_N, 8'h0F);
    chk(ctrl_q, 8'h8A);
    wr(REG_MODE_A, 8'h03);
    chk(ctrl_q, 8'h86);
    wr(REG_MODE_N, 8'h1F);
    chk(ctrl_q, 8'hC5);
    utter(3);
    chk(ctrl_q, 8'hC5);
  endtask

  // Reset holds everything idle and restores the reset image.
  task automatic reset_check();
    @(posedge clk) rstn <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    chk(ctrl_q, CTRL_IDLE);
    chk(cfg_image_q, CFG_RESET);
    @(posedge clk) rstn <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk(ctrl_q, 8'hFA);
  endtask

  // Main sequence: reset, then one task per scenario.
  initial begin
    rstn <= 1'b0;
    acoustic_erle = 8'h00;
    network_erle = 8'h00;
    utterance_done = 1'b0;
    repeat (3) @(posedge clk);
    #1;
    chk(ctrl_q, CTRL_IDLE);
    chk(cfg_image_q, CFG_RESET);
    @(posedge clk) rstn <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk(ctrl_q, 8'hFA);
    wr(REG_AC_THR, 8'h40);
    chk(cfg_image_q[3], 8'h40);
    short_frame();
    duplex();
    bypass_and_clear();
    reset_check();
    summarize();
  end
endmodule
`default_nettype wire
